// [common/sasr_pkg.sv]
package sasr_pkg;
    // Register offsets on the serial control port
    localparam logic [7:0] SASR_OFS_MAIN_STATUS = 8'h01;
    localparam logic [7:0] SASR_OFS_GEN_STATUS = 8'h05;
    localparam logic [7:0] SASR_OFS_ADC_STATUS = 8'h0d;
    localparam int SASR_MAIN_ADC_ERR_BIT = 11;

    // General status word layout
    localparam int SASR_RATIO_MSB = 15;
    localparam int SASR_RATIO_LSB = 12;
    localparam int SASR_RSV_MSB = 11;
    localparam int SASR_RSV_LSB = 8;
    localparam int SASR_CAUSE_MSB = 7;
    localparam int SASR_CAUSE_LSB = 5;
    localparam int SASR_STATE_MSB = 4;
    localparam int SASR_STATE_LSB = 0;

    // ADC block status word layout
    localparam int SASR_ADC_FLAG_W = 8;
    localparam int SASR_ADC_STOP_BIT = 7;
    localparam int SASR_ADC_TIMELINE_BIT = 6;
    localparam int SASR_ADC_CMD_BIT = 5;
    localparam int SASR_ADC_PARITY_BIT = 4;
    localparam int SASR_ADC_CH2_UNDER_BIT = 3;
    localparam int SASR_ADC_CH2_SAT_BIT = 2;
    localparam int SASR_ADC_CH1_UNDER_BIT = 1;
    localparam int SASR_ADC_CH1_SAT_BIT = 0;

    localparam logic [15:0] SASR_GEN_STATUS_RESET = 16'h0000;
    localparam logic [15:0] SASR_ADC_STATUS_RESET = 16'h0000;

    typedef logic [2:0] sasr_cause_t;
    localparam sasr_cause_t SASR_CAUSE_POWER_ON = 3'h0;
    localparam sasr_cause_t SASR_CAUSE_PROJ_LOW = 3'h1;
    localparam sasr_cause_t SASR_CAUSE_WD_ONE = 3'h2;
    localparam sasr_cause_t SASR_CAUSE_WD_TWO = 3'h3;
    localparam sasr_cause_t SASR_CAUSE_OVERTEMP = 3'h4;
    localparam sasr_cause_t SASR_CAUSE_SW_CYCLE = 3'h5;

    typedef logic [4:0] sasr_top_t;
    localparam sasr_top_t SASR_ST_SHUTDOWN = 5'h00;
    localparam sasr_top_t SASR_ST_INIT_A = 5'h01;
    localparam sasr_top_t SASR_ST_OFF = 5'h02;
    localparam sasr_top_t SASR_ST_INIT_B = 5'h03;
    localparam sasr_top_t SASR_ST_RAIL_1V1 = 5'h04;
    localparam sasr_top_t SASR_ST_RAIL_1V8 = 5'h05;
    localparam sasr_top_t SASR_ST_RAIL_3V3 = 5'h06;
    localparam sasr_top_t SASR_ST_RESET_RELEASE = 5'h07;
    localparam sasr_top_t SASR_ST_STANDBY = 5'h08;
    localparam sasr_top_t SASR_ST_OFFSET_ON = 5'h09;
    localparam sasr_top_t SASR_ST_BIAS_ON = 5'h0a;
    localparam sasr_top_t SASR_ST_DISPLAY_READY = 5'h0c;
    localparam sasr_top_t SASR_ST_DISPLAY_ON = 5'h0d;
    localparam sasr_top_t SASR_ST_PARK_INIT = 5'h0e;
    localparam sasr_top_t SASR_ST_BIAS_RESET_OFF = 5'h0f;
    localparam sasr_top_t SASR_ST_OFFSET_OFF = 5'h10;
    localparam sasr_top_t SASR_ST_DISCHARGE = 5'h11;

    // Ratio monitor: 30 MHz reference divided by 16 gives 8 edges in 85 core cycles
    localparam int SASR_WIN_W = 8;
    localparam int SASR_RATIO_WINDOW = 85;
    localparam logic [3:0] SASR_RATIO_MID = 4'h8;
endpackage

// [hw/sasr_ratio_mon.sv]
`timescale 1ns/10ps
module sasr_ratio_mon
    import sasr_pkg::*;
#(
    parameter int unsigned WINDOW = SASR_RATIO_WINDOW
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ext_ref_i,
    output logic [3:0] ratio_o
);
    localparam logic [SASR_WIN_W-1:0] WIN_LAST = SASR_WIN_W'(WINDOW - 1);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [SASR_WIN_W-1:0] win;
        logic [3:0] edges;
        logic [3:0] ratio;
    } sasr_mon_t;

    sasr_mon_t mon_reg;
    sasr_mon_t mon_next;
    logic rise;

    always_comb begin
        mon_next = mon_reg;
        mon_next.sync1 = ext_ref_i;
        mon_next.sync2 = mon_reg.sync1;
        mon_next.prev = mon_reg.sync2;
        rise = mon_reg.sync2 & ~mon_reg.prev;
        if (mon_reg.win == WIN_LAST) begin
            mon_next.win = '0;
            mon_next.ratio = mon_reg.edges;
            mon_next.edges = rise ? 4'h1 : 4'h0;
        end else begin
            mon_next.win = mon_reg.win + SASR_WIN_W'(1);
            // Saturate so a fast reference cannot wrap to a plausible value
            if (rise && mon_reg.edges != 4'hf) begin
                mon_next.edges = mon_reg.edges + 4'h1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            mon_reg <= '0;
        end else begin
            mon_reg <= mon_next;
        end
    end

    assign ratio_o = mon_reg.ratio;
endmodule

// [hw/sasr_status_regs.sv]
`timescale 1ns/10ps
// Contract
// - Clock ratio monitor value reads in general status bits 15 to 12.
// - Three-bit field holds the cause of the latest pass through off.
// - Cause codes 000 power-on, 001 projector-on low, 010/011 watchdogs.
// - Cause 100 means over-temperature, 101 software power cycle; others unused.
// - Top state code reads in bits 4 to 0 of status at 0x05.
// - Codes 0x00 to 0x07 cover shutdown, init, off, rails, reset release.
// - Codes 0x08 to 0x0D cover standby, mirror rails, display ready and on.
// - Codes 0x0E to 0x11 cover the parking sequence and discharge.
// - ADC status at 0x0D is readable; writing 1 sets a flag.
// - All ADC flags are ORed into one ADC error indication.
// - That indication feeds main status bit 11 at offset 0x01; here it only drives adc_block_error_o, and reads of 0x01 return zero.
// - Bit 7 sets when an ADC command lacks its stop bit.
// - Bit 6 sets when a command arrives while one is executing.
// - Bit 5 sets on a malformed ADC serial command.
// - Bit 4 sets on a parity error in the command stream.
// - Bits 3 and 2 set on channel two underflow and saturation.
// - Bits 1 and 0 set on channel one underflow and saturation.
module sasr_status_regs
    import sasr_pkg::*;
#(
    parameter int unsigned RATIO_WINDOW = SASR_RATIO_WINDOW
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic ext_ref_div_i,
    input wire logic [4:0] top_state_i,
    input wire logic projector_on_input_fell_i,
    input wire logic watchdog_one_error_i,
    input wire logic watchdog_two_error_i,
    input wire logic die_overtemp_i,
    input wire logic sw_power_cycle_i,
    input wire logic adc_serial_command_link_stop_err_i,
    input wire logic adc_serial_command_link_start_i,
    input wire logic adc_serial_command_link_busy_i,
    input wire logic adc_serial_command_link_cmd_err_i,
    input wire logic adc_serial_command_link_parity_err_i,
    input wire logic ch2_underflow_i,
    input wire logic ch2_saturated_i,
    input wire logic ch1_underflow_i,
    input wire logic ch1_saturated_i,
    output logic adc_block_error_o
);
    typedef struct packed {
        logic [SASR_ADC_FLAG_W-1:0] adc_flags;
        sasr_cause_t cause;
        sasr_cause_t pending;
        sasr_top_t prev_state;
        logic [15:0] rdata;
        logic rvalid;
        logic adc_err;
    } sasr_state_t;

    localparam sasr_state_t RESET_STATE = '{
        adc_flags: SASR_ADC_STATUS_RESET[SASR_ADC_FLAG_W-1:0],
        cause: SASR_CAUSE_POWER_ON,
        pending: SASR_CAUSE_POWER_ON,
        prev_state: SASR_ST_SHUTDOWN,
        rdata: SASR_GEN_STATUS_RESET,
        rvalid: 1'b0,
        adc_err: 1'b0
    };

    sasr_state_t state_reg;
    sasr_state_t state_next;
    logic [3:0] ratio;
    logic [SASR_ADC_FLAG_W-1:0] hw_set;
    logic [SASR_ADC_FLAG_W-1:0] sw_set;
    logic enter_off;

    function automatic logic sasr_is_off(input sasr_top_t code);
        return code == SASR_ST_OFF;
    endfunction

    sasr_ratio_mon #(
        .WINDOW(RATIO_WINDOW)
    ) u_ratio_mon (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .ext_ref_i(ext_ref_div_i),
        .ratio_o(ratio)
    );

    always_comb begin
        state_next = state_reg;

        hw_set = '0;
        hw_set[SASR_ADC_STOP_BIT] = adc_serial_command_link_stop_err_i;
        hw_set[SASR_ADC_TIMELINE_BIT] = adc_serial_command_link_start_i
            & adc_serial_command_link_busy_i;
        hw_set[SASR_ADC_CMD_BIT] = adc_serial_command_link_cmd_err_i;
        hw_set[SASR_ADC_PARITY_BIT] = adc_serial_command_link_parity_err_i;
        hw_set[SASR_ADC_CH2_UNDER_BIT] = ch2_underflow_i;
        hw_set[SASR_ADC_CH2_SAT_BIT] = ch2_saturated_i;
        hw_set[SASR_ADC_CH1_UNDER_BIT] = ch1_underflow_i;
        hw_set[SASR_ADC_CH1_SAT_BIT] = ch1_saturated_i;

        sw_set = '0;
        if (reg_wr_i && reg_addr_i == SASR_OFS_ADC_STATUS) begin
            sw_set = reg_wdata_i[SASR_ADC_FLAG_W-1:0];
        end
        // Flags have no clear path, so nothing can race a set
        state_next.adc_flags = state_reg.adc_flags | hw_set | sw_set;

        // OR of flags, drives adc_block_error_o only
        state_next.adc_err = |state_next.adc_flags;

        // cause priority, most severe wins in one cycle
        if (die_overtemp_i) begin
            state_next.pending = SASR_CAUSE_OVERTEMP;
        end else if (watchdog_one_error_i) begin
            state_next.pending = SASR_CAUSE_WD_ONE;
        end else if (watchdog_two_error_i) begin
            state_next.pending = SASR_CAUSE_WD_TWO;
        end else if (projector_on_input_fell_i) begin
            state_next.pending = SASR_CAUSE_PROJ_LOW;
        end else if (sw_power_cycle_i) begin
            state_next.pending = SASR_CAUSE_SW_CYCLE;
        end

        enter_off = sasr_is_off(top_state_i) && !sasr_is_off(state_reg.prev_state);
        if (enter_off) begin
            state_next.cause = state_next.pending;
        end
        state_next.prev_state = top_state_i;

        // Writes to the general status word are ignored
        state_next.rvalid = reg_rd_i;
        state_next.rdata = '0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                SASR_OFS_GEN_STATUS: begin
                    state_next.rdata[SASR_RATIO_MSB:SASR_RATIO_LSB] = ratio;
                    state_next.rdata[SASR_CAUSE_MSB:SASR_CAUSE_LSB] = state_reg.cause;
                    state_next.rdata[SASR_STATE_MSB:SASR_STATE_LSB] = top_state_i;
                end
                SASR_OFS_ADC_STATUS: begin
                    state_next.rdata[SASR_ADC_FLAG_W-1:0] = state_reg.adc_flags;
                end
                default: begin
                    state_next.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_o = state_reg.rdata;
    assign reg_rvalid_o = state_reg.rvalid;
    assign adc_block_error_o = state_reg.adc_err;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    logic rd_gen;
    logic rd_adc;
    logic wr_adc;
    assign rd_gen = reg_rd_i && reg_addr_i == SASR_OFS_GEN_STATUS;
    assign rd_adc = reg_rd_i && reg_addr_i == SASR_OFS_ADC_STATUS;
    assign wr_adc = reg_wr_i && reg_addr_i == SASR_OFS_ADC_STATUS;

    ratio_field_a: assert property (
        rd_gen |=> reg_rvalid_o
            && reg_rdata_o[SASR_RATIO_MSB:SASR_RATIO_LSB] == $past(ratio))
        else $error("ratio field does not match monitor");

    cause_field_a: assert property (
        rd_gen |=> reg_rdata_o[SASR_CAUSE_MSB:SASR_CAUSE_LSB] == $past(state_reg.cause))
        else $error("cause field does not match held cause");

    off_commit_a: assert property (
        enter_off |=> state_reg.cause == $past(state_next.pending))
        else $error("cause not captured on entry to off");

    cause_hold_a: assert property (
        !enter_off |=> $stable(state_reg.cause))
        else $error("cause changed outside entry to off");

    wd_one_code_a: assert property (
        watchdog_one_error_i && !die_overtemp_i |=> state_reg.pending == SASR_CAUSE_WD_ONE)
        else $error("watchdog one cause code wrong");

    proj_code_a: assert property (
        projector_on_input_fell_i && !die_overtemp_i && !watchdog_one_error_i
            && !watchdog_two_error_i |=> state_reg.pending == SASR_CAUSE_PROJ_LOW)
        else $error("projector-on cause code wrong");

    overtemp_code_a: assert property (
        die_overtemp_i |=> state_reg.pending == SASR_CAUSE_OVERTEMP)
        else $error("over-temperature cause code wrong");

    cause_range_a: assert property (
        state_reg.cause <= SASR_CAUSE_SW_CYCLE)
        else $error("unused cause code reported");

    state_field_a: assert property (
        rd_gen |=> reg_rdata_o[SASR_STATE_MSB:SASR_STATE_LSB] == $past(top_state_i))
        else $error("top state field wrong");

    gen_reserved_a: assert property (
        rd_gen |=> reg_rdata_o[SASR_RSV_MSB:SASR_RSV_LSB] == 4'h0)
        else $error("general status reserved bits not zero");

    adc_reserved_a: assert property (
        rd_adc |=> reg_rdata_o[15:SASR_ADC_FLAG_W] == 8'h00)
        else $error("ADC status upper byte not zero");

    adc_readback_a: assert property (
        rd_adc |=> reg_rdata_o[SASR_ADC_FLAG_W-1:0] == $past(state_reg.adc_flags))
        else $error("ADC status read-back wrong");

    w1s_set_a: assert property (
        wr_adc |=> (state_reg.adc_flags & $past(reg_wdata_i[SASR_ADC_FLAG_W-1:0]))
            == $past(reg_wdata_i[SASR_ADC_FLAG_W-1:0]))
        else $error("write of one did not set flag");

    flags_sticky_a: assert property (
        ##1 (state_reg.adc_flags & $past(state_reg.adc_flags))
            == $past(state_reg.adc_flags))
        else $error("ADC flag cleared without reset");

    adc_or_a: assert property (
        adc_block_error_o == (|state_reg.adc_flags))
        else $error("ADC error not OR of flags");

    adc_err_rise_a: assert property (
        !adc_block_error_o && (|hw_set) |=> adc_block_error_o)
        else $error("ADC error not raised one cycle after event");

    stop_bit_a: assert property (
        adc_serial_command_link_stop_err_i |=> state_reg.adc_flags[SASR_ADC_STOP_BIT])
        else $error("stop bit flag not set");

    timeline_a: assert property (
        adc_serial_command_link_start_i && adc_serial_command_link_busy_i
            |=> state_reg.adc_flags[SASR_ADC_TIMELINE_BIT])
        else $error("timeline flag not set");

    timeline_idle_a: assert property (
        !state_reg.adc_flags[SASR_ADC_TIMELINE_BIT] && !adc_serial_command_link_busy_i
            && !wr_adc |=> !state_reg.adc_flags[SASR_ADC_TIMELINE_BIT])
        else $error("timeline flag set without overlap");

    cmd_err_a: assert property (
        adc_serial_command_link_cmd_err_i |=> state_reg.adc_flags[SASR_ADC_CMD_BIT])
        else $error("command error flag not set");

    parity_a: assert property (
        adc_serial_command_link_parity_err_i |=> state_reg.adc_flags[SASR_ADC_PARITY_BIT])
        else $error("parity flag not set");

    ch2_flags_a: assert property (
        ch2_underflow_i && ch2_saturated_i |=> state_reg.adc_flags[3:2] == 2'h3)
        else $error("channel two flags not set");

    ch1_flags_a: assert property (
        ch1_underflow_i && ch1_saturated_i |=> state_reg.adc_flags[1:0] == 2'h3)
        else $error("channel one flags not set");

    ratio_mid_c: cover property (rd_gen ##1 reg_rdata_o[15:12] == SASR_RATIO_MID);
    wd_off_c: cover property (watchdog_one_error_i ##[1:20] enter_off);
    display_on_c: cover property (rd_gen && top_state_i == SASR_ST_DISPLAY_ON);
    discharge_c: cover property (rd_gen && top_state_i == SASR_ST_DISCHARGE);
    sw_force_c: cover property (wr_adc ##1 rd_adc ##1 reg_rdata_o[7:0] != 8'h00);
endmodule

// [tb/sasr_host_model.sv]
`timescale 1ns/10ps
module sasr_host_model (
    input wire logic clock_i,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [15:0] reg_wdata_o
);
    initial begin
        reg_addr_o = 8'hff;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end

    task automatic write_word(input logic [7:0] addr, input logic [15:0] data);
        @(posedge clock_i);
        reg_addr_o <= addr;
        reg_wdata_o <= data;
        reg_wr_o <= 1'b1;
        @(posedge clock_i);
        reg_wr_o <= 1'b0;
        // Released lines show the inverse so stale values never look live
        reg_addr_o <= ~addr;
        reg_wdata_o <= ~data;
    endtask

    // Answer registers on the taken edge and stands for the cycle after it only
    task automatic read_word(input logic [7:0] addr, output logic [15:0] data,
                             output logic ok);
        @(posedge clock_i);
        reg_addr_o <= addr;
        reg_rd_o <= 1'b1;
        @(posedge clock_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~addr;
        @(negedge clock_i);
        ok = reg_rvalid_i;
        data = reg_rdata_i;
    endtask
endmodule

// [tb/tb_sasr_status_regs.sv]
`timescale 1ns/10ps
module tb_sasr_status_regs
    import sasr_pkg::*;
;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic ext_ref = 1'b0;
    logic ref_en = 1'b0;
    logic [4:0] acc = 5'h00;
    logic [4:0] top_state = 5'h08;
    logic [4:0] cause_ev = 5'h00;
    logic [7:0] adc_ev = 8'h00;
    logic busy = 1'b0;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic adc_err;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    sasr_status_regs dut (
        .clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .reg_rvalid_o(reg_rvalid), .ext_ref_div_i(ext_ref), .top_state_i(top_state),
        .projector_on_input_fell_i(cause_ev[0]), .watchdog_one_error_i(cause_ev[1]),
        .watchdog_two_error_i(cause_ev[2]), .die_overtemp_i(cause_ev[3]),
        .sw_power_cycle_i(cause_ev[4]), .adc_serial_command_link_stop_err_i(adc_ev[7]),
        .adc_serial_command_link_start_i(adc_ev[6]), .adc_serial_command_link_busy_i(busy),
        .adc_serial_command_link_cmd_err_i(adc_ev[5]),
        .adc_serial_command_link_parity_err_i(adc_ev[4]), .ch2_underflow_i(adc_ev[3]),
        .ch2_saturated_i(adc_ev[2]), .ch1_underflow_i(adc_ev[1]),
        .ch1_saturated_i(adc_ev[0]), .adc_block_error_o(adc_err)
    );

    sasr_host_model host (
        .clock_i(clock_i), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid),
        .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata)
    );

    initial begin
        forever #25 clock_i = ~clock_i;
    end

    // Divided 30 MHz reference: toggles every 16/3 core cycles on average
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (ref_en) begin
            acc <= (acc + 5'h03 >= 5'h10) ? acc + 5'h03 - 5'h10 : acc + 5'h03;
            if (acc + 5'h03 >= 5'h10) begin
                ext_ref <= ~ext_ref;
            end
        end
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [15:0] mask,
                          input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host.read_word(addr, d, ok);
        check({15'h0000, ok}, 16'h0001);
        check(d & mask, exp);
    endtask

    task automatic do_reset();
        @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic test_reset_values();
        rd_chk(SASR_OFS_GEN_STATUS, 16'hffe0, 16'h0000);
        rd_chk(SASR_OFS_ADC_STATUS, 16'hffff, 16'h0000);
        check({15'h0000, adc_err}, 16'h0000);
    endtask

    task automatic test_adc_events();
        logic [7:0] exp;
        exp = 8'h00;
        // A new command with nothing in progress is not a timeline error
        @(posedge clock_i);
        adc_ev <= 8'h40;
        @(posedge clock_i);
        adc_ev <= 8'h00;
        rd_chk(SASR_OFS_ADC_STATUS, 16'hffff, 16'h0000);
        @(posedge clock_i);
        busy <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock_i);
            adc_ev <= 8'h01 << i;
            @(posedge clock_i);
            adc_ev <= 8'h00;
            // The reset at the end of each pass clears the flags, so one bit per pass
            exp = 8'h01 << i;
            @(negedge clock_i);
            check({15'h0000, adc_err}, 16'h0001);
            rd_chk(SASR_OFS_ADC_STATUS, 16'hffff, {8'h00, exp});
            do_reset();
        end
        busy <= 1'b0;
    endtask

    task automatic test_w1s();
        host.write_word(SASR_OFS_ADC_STATUS, 16'hff41);
        @(negedge clock_i);
        check({15'h0000, adc_err}, 16'h0001);
        rd_chk(SASR_OFS_ADC_STATUS, 16'hffff, 16'h0041);
        host.write_word(SASR_OFS_ADC_STATUS, 16'h0002);
        rd_chk(SASR_OFS_ADC_STATUS, 16'hffff, 16'h0043);
        host.write_word(SASR_OFS_GEN_STATUS, 16'hffff);
        rd_chk(SASR_OFS_GEN_STATUS, 16'hffe0, 16'h0000);
        rd_chk(8'h33, 16'hffff, 16'h0000);
    endtask

    task automatic test_states();
        for (int i = 0; i <= 17; i++) begin
            if (i != 11) begin
                @(posedge clock_i);
                top_state <= i[4:0];
                rd_chk(SASR_OFS_GEN_STATUS, 16'h0f1f, {11'h000, i[4:0]});
            end
        end
        @(posedge clock_i);
        top_state <= SASR_ST_STANDBY;
    endtask

    task automatic test_causes();
        for (int i = 0; i < 5; i++) begin
            @(posedge clock_i);
            cause_ev <= 5'h01 << i;
            @(posedge clock_i);
            cause_ev <= 5'h00;
            repeat (2) @(posedge clock_i);
            top_state <= SASR_ST_OFF;
            repeat (2) @(posedge clock_i);
            rd_chk(SASR_OFS_GEN_STATUS, 16'h00e0, {8'h00, 3'(i + 1), 5'h00});
            @(posedge clock_i);
            top_state <= SASR_ST_STANDBY;
        end
    endtask

    task automatic test_ratio();
        logic [15:0] d;
        logic ok;
        ref_en <= 1'b1;
        repeat (400) @(posedge clock_i);
        host.read_word(SASR_OFS_GEN_STATUS, d, ok);
        n_compared++;
        // A 30 MHz reference must read mid-scale within one count
        if (d[15:12] !== 4'h7 && d[15:12] !== 4'h8 && d[15:12] !== 4'h9) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, d[15:12], SASR_RATIO_MID);
        end
        ref_en <= 1'b0;
    endtask

    task automatic conclude();
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        test_reset_values();
        test_adc_events();
        test_w1s();
        test_states();
        test_causes();
        test_ratio();
        conclude();
    end
endmodule
